// *** rtl/rcd_top.sv ***
// regional clock divider: passes or divides a pin clock onto a region's nets
// assumes src_clk is far slower than ref_clk (at least four ref periods per
// half period) and is sampled; output edges follow input edges by a fixed lag
module rcd_top #(
  parameter int unsigned DIVIDE_RATIO = rcd_pkg::RATIO_BYPASS  // 0 bypass, else 1..8
) (
  input wire logic ref_clk,           // reference clock, 10 MHz
  input wire logic nrst,              // async reset, active low
  input wire logic clk_en,            // clock enable, freezes all state when low
  input wire logic src_clk,           // input clock from pin or interconnect
  input wire logic out_enable,        // output enable, numeric ratios only
  input wire logic divider_clear,     // async divider clear, active high
  input wire logic global_set_reset,  // device-wide set/reset, active high
  output logic region_clk,            // clock to the region nets
  output logic running                // output currently allowed to toggle
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration

  localparam bit IS_BYPASS = (DIVIDE_RATIO == rcd_pkg::RATIO_BYPASS);
  // ratio above eight falls back to the largest legal ratio
  localparam int unsigned CNT_RATIO = IS_BYPASS ? rcd_pkg::RATIO_MIN :
                                      (DIVIDE_RATIO > rcd_pkg::RATIO_MAX) ? rcd_pkg::RATIO_MAX :
                                      DIVIDE_RATIO;
  localparam bit IS_UNITY = !IS_BYPASS && (CNT_RATIO == rcd_pkg::RATIO_MIN);
  localparam rcd_pkg::rcd_cnt_t CNT_LAST = rcd_pkg::rcd_last(CNT_RATIO);
  localparam rcd_pkg::rcd_cnt_t CNT_HIGH = rcd_pkg::rcd_high_len(CNT_RATIO);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [2:0] pins_s;
  logic src_s;
  logic en_s;
  logic set_reset_s;
  logic src_prev_q;
  logic rise;
  logic run;
  logic div_rst_n;
  logic region_clk_q;
  logic running_q;

  rcd_div_if div ();

  rcd_sync #(
    .W(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .d({src_clk, out_enable, global_set_reset}),
    .q(pins_s)
  );

  assign src_s = pins_s[2];
  assign en_s = pins_s[1];
  assign set_reset_s = pins_s[0];

  // one more stage on the clock line to find its rising edge
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      src_prev_q <= 1'h0;
    else if (clk_en)
      src_prev_q <= src_s;
  end

  assign rise = src_s && !src_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // clear and run qualification

  // clear only reaches the divider when a numeric ratio is set
  assign div_rst_n = nrst && !(divider_clear && !IS_BYPASS);

  // enable counts only for numeric ratios; set/reset always blocks
  assign run = (IS_BYPASS || en_s) && !set_reset_s;

  // counter held at its restart point while set/reset is high, so the
  // first edge after release begins a fresh high phase
  assign div.restart = set_reset_s;
  assign div.step = rise && run;

  rcd_divcount #(
    .RATIO(CNT_RATIO)
  ) u_count (
    .ref_clk(ref_clk),
    .clear_n(div_rst_n),
    .clk_en(clk_en),
    .div(div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output stage

  // output register; every numeric ratio updates at the same point after the
  // sampled input edge, so alignment never depends on the ratio
  always_ff @(posedge ref_clk or negedge div_rst_n)
  begin
    if (!div_rst_n)
      region_clk_q <= rcd_pkg::OUT_RESET;
    else if (clk_en)
    begin
      if (IS_BYPASS)
      begin
        if (!set_reset_s)
          region_clk_q <= src_s;
      end
      else if (IS_UNITY)
      begin
        // only input edges move it, so a late enable never makes a half pulse
        if (run && (src_s != src_prev_q))
          region_clk_q <= src_s;
      end
      else if (div.step)
        region_clk_q <= div.phase_high;
    end
  end

  // status: toggling permitted and divider not cleared
  always_ff @(posedge ref_clk or negedge div_rst_n)
  begin
    if (!div_rst_n)
      running_q <= rcd_pkg::OUT_RESET;
    else if (clk_en)
      running_q <= run;
  end

  assign region_clk = region_clk_q;
  assign running = running_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // counter never leaves the positions of the configured ratio
  AST_CNT_RANGE: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    !IS_BYPASS |-> div.count <= CNT_LAST
  ) else $error("divide counter beyond last position");

  // bypass output copies the sampled input one cycle later
  AST_BYPASS_FOLLOW: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (IS_BYPASS && clk_en && !set_reset_s) |=> region_clk_q == $past(src_s)
  ) else $error("bypass output does not follow input");

  // enable has no say in bypass
  AST_BYPASS_NO_EN: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    IS_BYPASS |-> run == !set_reset_s
  ) else $error("enable gated a bypass clock");

  // clear holds output low and counter at restart
  AST_CLEAR_LOW: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (divider_clear && !IS_BYPASS) |-> (!region_clk_q && div.count == CNT_LAST)
  ) else $error("clear did not force output low");

  // disabled output stays put over three cycles
  AST_EN_STOP: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !en_s) [*3] |-> $stable(region_clk_q)
  ) else $error("output toggled while disabled");

  // set/reset freezes the output
  AST_SETRESET_STATIC: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    ($past(set_reset_s) && set_reset_s) |-> $stable(region_clk_q)
  ) else $error("output toggled during set/reset");

  // set/reset parks the counter so release restarts the sequence
  AST_SETRESET_PARK: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && set_reset_s && clk_en) |=> div.count == CNT_LAST
  ) else $error("counter not parked during set/reset");

  // after each step the output is high exactly on the first floor(ratio/2) positions
  AST_PHASES: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !IS_UNITY && clk_en && div.step) |=> region_clk_q == (div.count < CNT_HIGH)
  ) else $error("divided phase lengths wrong");

  // every numeric rising output edge follows a sampled input edge by one cycle
  AST_ALIGN: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && $rose(region_clk_q)) |-> $past(rise)
  ) else $error("output edge misaligned with input edge");

  // after clear the first output rise comes on the first counted edge
  AST_CLEAR_RESUME: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !IS_UNITY && div.count == CNT_LAST && div.step && clk_en) |=> region_clk_q
  ) else $error("sequence did not restart with a high phase");

  // status register follows the run qualifier one cycle later
  AST_RUN_TRACK: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    clk_en |=> running_q == $past(run)
  ) else $error("status does not track run");

  // set/reset drops the status
  AST_SETRESET_NOT_RUN: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (set_reset_s && clk_en) |=> !running_q
  ) else $error("status high during set/reset");

  // bypass runs whenever set/reset is low
  AST_BYPASS_RUN: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (IS_BYPASS && !set_reset_s && clk_en) |=> running_q
  ) else $error("bypass status low without set/reset");

  // numeric ratios run while enabled and out of set/reset
  AST_EN_RUN: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && en_s && !set_reset_s && clk_en) |=> running_q
  ) else $error("status low while enabled");

  // clear drops the status at once
  AST_CLEAR_NOT_RUN: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (divider_clear && !IS_BYPASS) |-> !running_q
  ) else $error("status high during clear");

  // counter moves only on rising input edges
  AST_COUNT_HOLD: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && clk_en && !rise && !set_reset_s) |=> $stable(div.count)
  ) else $error("counter moved without an input edge");

  // counter advances by one below the last position
  AST_COUNT_ADV: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && clk_en && div.step && !div.wrap) |=> div.count == $past(div.count) + rcd_pkg::rcd_cnt_t'(1)
  ) else $error("counter did not advance by one");

  // counter returns to zero after the last position
  AST_COUNT_WRAP: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && clk_en && div.step && div.wrap) |=> div.count == '0
  ) else $error("counter did not wrap to zero");

  // disabled counter is frozen, not parked
  AST_EN_FREEZE_COUNT: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !en_s && !set_reset_s && clk_en) |=> $stable(div.count)
  ) else $error("counter moved while disabled");

  // ratio one copies every input edge
  AST_UNITY_FOLLOW: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (IS_UNITY && clk_en && run && (src_s != src_prev_q)) |=> region_clk_q == $past(src_s)
  ) else $error("ratio one output missed an input edge");

  // ratio one never moves between input edges
  AST_UNITY_HOLD: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (IS_UNITY && (src_s == src_prev_q)) |=> $stable(region_clk_q)
  ) else $error("ratio one output moved without an input edge");

  // divided outputs move only on a sampled rising input edge
  AST_NUM_EDGE_ONLY: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !IS_UNITY && !rise) |=> $stable(region_clk_q)
  ) else $error("divided output moved without an input edge");

  // a divided high phase only starts from the last position
  AST_RISE_AT_WRAP: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !IS_UNITY && $rose(region_clk_q)) |-> $past(div.wrap)
  ) else $error("high phase started mid sequence");

  // stopped numeric output holds its level
  AST_STOPPED_STABLE: assert property (
    @(posedge ref_clk) disable iff (!div_rst_n)
    (!IS_BYPASS && !running_q) |-> $stable(region_clk_q)
  ) else $error("output moved while stopped");

  // bypass keeps following while the enable is low
  AST_BYPASS_IGNORES_EN: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (IS_BYPASS && !en_s && !set_reset_s && clk_en) |=> region_clk_q == $past(src_s)
  ) else $error("bypass output stopped by enable");

  // bypass keeps following while the clear is high
  AST_BYPASS_IGNORES_CLEAR: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (IS_BYPASS && divider_clear && !set_reset_s && clk_en) |=> region_clk_q == $past(src_s)
  ) else $error("bypass output stopped by clear");

endmodule

// *** common/rcd_pkg.sv ***
// constants, types and helpers shared by the regional clock divider
// assumes a single reference clock domain; all users reference names scoped
package rcd_pkg;

  // divide ratio limits and the code that selects bypass
  localparam int unsigned RATIO_MIN = 1;
  localparam int unsigned RATIO_MAX = 8;
  localparam int unsigned RATIO_BYPASS = 0;

  // divide counter width, enough for positions 0 .. RATIO_MAX-1
  localparam int unsigned CNT_W = 3;

  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_DEPTH = 2;

  // reference clock period in ns, for documentation of latency
  localparam int unsigned REF_PERIOD_NS = 100;

  // reset value of the output and of the status flag
  localparam logic OUT_RESET = 1'h0;

  typedef logic [CNT_W-1:0] rcd_cnt_t;

  // last counter position for a ratio, also the restart position
  function automatic rcd_cnt_t rcd_last(input int unsigned ratio);
    rcd_cnt_t last;
    last = rcd_cnt_t'(ratio - 1);
    return last;
  endfunction

  // number of input periods the output stays high (floor of half)
  function automatic rcd_cnt_t rcd_high_len(input int unsigned ratio);
    rcd_cnt_t len;
    len = rcd_cnt_t'(ratio / 2);
    return len;
  endfunction

endpackage

// *** common/rcd_div_if.sv ***
// carrier between the divider control and its counter
// assumes both ends sit on the same reference clock
interface rcd_div_if;
  logic step;                // advance one input period
  logic restart;             // synchronous return to the last position
  rcd_pkg::rcd_cnt_t count;  // current position
  logic wrap;                // current position is the last one
  logic phase_high;          // output level after the next step

  modport ctl (output step, output restart, input count, input wrap, input phase_high);
  modport cnt (input step, input restart, output count, output wrap, output phase_high);
endinterface

// *** rtl/rcd_sync.sv ***
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous levels; stage one feeds stage two only
module rcd_sync #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk,        // reference clock
  input wire logic nrst,           // async reset, active low
  input wire logic clk_en,         // freezes both stages when low
  input wire logic [W-1:0] d,      // asynchronous inputs
  output logic [W-1:0] q           // synchronised levels
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // metastability filter, resets to all low
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// *** rtl/rcd_divcount.sv ***
// divide counter: walks positions 0 .. ratio-1 on each step
// assumes steps come one per rising input edge; clear is asynchronous
module rcd_divcount #(
  parameter int unsigned RATIO = 2
) (
  input wire logic ref_clk,        // reference clock
  input wire logic clear_n,        // async clear, active low
  input wire logic clk_en,         // freezes the counter when low
  rcd_div_if.cnt div               // step and restart in, position out
);

  localparam rcd_pkg::rcd_cnt_t LAST = rcd_pkg::rcd_last(RATIO);
  localparam rcd_pkg::rcd_cnt_t HIGH_LEN = rcd_pkg::rcd_high_len(RATIO);

  rcd_pkg::rcd_cnt_t cnt_q;
  rcd_pkg::rcd_cnt_t cnt_d;

  // next position; parked at the last one so the first step lands on zero
  always_comb
  begin
    if (cnt_q == LAST)
      cnt_d = '0;
    else
      cnt_d = cnt_q + rcd_pkg::rcd_cnt_t'(1);
  end

  // position register, clear restarts the sequence
  always_ff @(posedge ref_clk or negedge clear_n)
  begin
    if (!clear_n)
      cnt_q <= LAST;
    else if (clk_en)
    begin
      if (div.restart)
        cnt_q <= LAST;
      else if (div.step)
        cnt_q <= cnt_d;
    end
  end

  // high for the first floor(ratio/2) positions, so odd ratios run long low
  assign div.phase_high = (cnt_d < HIGH_LEN);
  assign div.count = cnt_q;
  assign div.wrap = (cnt_q == LAST);

endmodule

// *** tb/rcd_src_model.sv ***
// partner model: clock source on a clock-capable pin feeding the divider
// assumes the bench owns ref_clk; src_clk only moves on falling ref edges
module rcd_src_model #(
  parameter int HALF = 4
) (
  input wire logic ref_clk, // reference clock
  input wire logic run,     // clock present while high
  output logic src_clk      // source clock to the divider
);
  timeunit 1ns;
  timeprecision 1ns;

  int cnt = 0;

  initial src_clk = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // stands low while stopped, so no stray edge reaches the divider
  always @(negedge ref_clk)
  begin
    if (!run)
    begin
      cnt = 0;
      src_clk = 1'h0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt = 0;
      src_clk = ~src_clk;
    end
    else
      cnt = cnt + 1;
  end
endmodule

// *** tb/regional_clock_divider_bench.sv ***
// self-checking bench: one divider each for ratios 1, 2, 3 and 8, bypass included, on shared inputs
// assumes the source model runs at eight ref periods per input period
module regional_clock_divider_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int NR = 5;
  localparam int RAT [NR] = '{0, 1, 2, 3, 8};
  localparam int PER = 8; // input period in ref cycles

  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic out_enable = 1'h1;
  logic divider_clear = 1'h0;
  logic global_set_reset = 1'h0;
  logic src_run = 1'h0;
  logic src_clk;
  logic [NR-1:0] rclk;
  logic [NR-1:0] run;
  int error_cnt = 0;
  int total_checks = 0;
  int tg [NR];

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz reference clock
  initial forever #50 ref_clk = ~ref_clk;

  rcd_src_model #(.HALF(PER / 2)) i_src (.ref_clk(ref_clk), .run(src_run), .src_clk(src_clk));

  // one divider per entry of RAT; same inputs so alignment can be compared
  for (genvar g = 0; g < NR; g++)
  begin : g_r
    rcd_top #(.DIVIDE_RATIO(RAT[g])) i_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'h1),
      .src_clk(src_clk), .out_enable(out_enable), .divider_clear(divider_clear),
      .global_set_reset(global_set_reset), .region_clk(rclk[g]), .running(run[g]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected phase lengths; ratio one and bypass follow the input
  function automatic int hi_len(input int r);
    return (r < 2) ? PER / 2 : (r / 2) * PER;
  endfunction

  function automatic int lo_len(input int r);
    return (r < 2) ? PER / 2 : (r - r / 2) * PER;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // sample just after the rising edge so its updates have landed
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task wait_lvl(input int k, input logic v);
    for (int i = 0; i < 200 && rclk[k] !== v; i++) step(1);
    if (rclk[k] !== v)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t output wait ran out", $time);
      complete_run;
    end
  endtask

  task count_tg(input int n);
    logic [NR-1:0] prev;
    tg = '{default: 0};
    prev = rclk;
    repeat (n)
    begin
      step(1);
      for (int k = 0; k < NR; k++) if (rclk[k] !== prev[k]) tg[k]++;
      prev = rclk;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // steady high and low lengths for every ratio
  task t_period;
    int hi;
    int lo;
    for (int k = 0; k < NR; k++)
    begin
      wait_lvl(k, 1'h0);
      wait_lvl(k, 1'h1);
      hi = 0;
      lo = 0;
      while (rclk[k] === 1'h1 && hi < 100) begin step(1); hi++; end
      while (rclk[k] === 1'h0 && lo < 100) begin step(1); lo++; end
      chk(hi, hi_len(RAT[k]));
      chk(lo, lo_len(RAT[k]));
      chk(run[k], 1'h1);
    end
  endtask

  // clear mid-run, then a restarted sequence common to all numeric ratios
  task t_clear;
    int c [NR];
    @(negedge ref_clk);
    divider_clear = 1'h1;
    #1;
    for (int k = 1; k < NR; k++) chk({rclk[k], run[k]}, 2'h0);
    count_tg(40);
    for (int k = 0; k < NR; k++) chk(tg[k] > 0, RAT[k] == 0);
    @(negedge ref_clk);
    divider_clear = 1'h0;
    wait_lvl(1, 1'h1);
    for (int k = 1; k < NR; k++) chk(rclk[k], 1'h1);
    c = '{default: 0};
    for (int i = 1; i <= 40; i++)
    begin
      step(1);
      for (int k = 1; k < NR; k++) if (c[k] == 0 && rclk[k] !== 1'h1) c[k] = i;
    end
    for (int k = 1; k < NR; k++) chk(c[k], hi_len(RAT[k]));
  endtask

  // enable off freezes numeric ratios only, on restarts them
  task t_enable;
    @(negedge ref_clk);
    out_enable = 1'h0;
    step(4);
    count_tg(40);
    for (int k = 0; k < NR; k++) chk(tg[k] > 0, RAT[k] == 0);
    @(negedge ref_clk);
    out_enable = 1'h1;
    step(4);
    count_tg(80);
    for (int k = 0; k < NR; k++) chk(tg[k] > 0, 1'h1);
  endtask

  // set/reset freezes every output, release lets them run again
  task t_gsr;
    @(negedge ref_clk);
    global_set_reset = 1'h1;
    step(4);
    count_tg(40);
    for (int k = 0; k < NR; k++) chk({tg[k] > 0, run[k]}, 2'h0);
    @(negedge ref_clk);
    global_set_reset = 1'h0;
    step(4);
    count_tg(80);
    for (int k = 0; k < NR; k++) chk(tg[k] > 0, 1'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence; every wait is bounded so the run always ends in complete_run
  initial
  begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'h1;
    count_tg(20);
    for (int k = 0; k < NR; k++) chk(tg[k], 0);
    @(negedge ref_clk);
    src_run = 1'h1;
    t_period;
    t_clear;
    t_enable;
    t_gsr;
    t_period;
    complete_run;
  end
endmodule
